// ==== core/scr_regs.vh ====
// constants of the save and configuration register bank
// assumes a 200 MHz sys_clk and an 8-bit serial byte stream with framing bit 7
`ifndef SCR_REGS_VH
`define SCR_REGS_VH

// ***************************************************************
// serial frame
// ***************************************************************
`define SCR_FRAME_START 8'h80
`define SCR_MASK7 7'h7f
`define SCR_CMD_WR_SAVE1 8'h72
`define SCR_CMD_WR_SAVE2 8'h73
`define SCR_CMD_WR_CFG1 8'h74
`define SCR_CMD_WR_CFG2 8'h75
`define SCR_CMD_RD_SAVE1 8'h32
`define SCR_CMD_RD_SAVE2 8'h33
`define SCR_CMD_RD_CFG1 8'h34
`define SCR_CMD_RD_CFG2 8'h35

// ***************************************************************
// register fields and reset values
// ***************************************************************
`define SCR_SAVE1_MASK 14'h3bff
`define SCR_SAVE2_MASK 14'h001f
`define SCR_CFG1_MASK 14'h1e1f
`define SCR_CFG2_MASK 14'h01c6
`define SCR_SAVE1_RESET 14'h0000
`define SCR_SAVE2_RESET 14'h0000
`define SCR_CFG1_RESET 14'h0000
`define SCR_CFG2_RESET 14'h0000
`define SCR_CFG1_DIR_MSB 12
`define SCR_CFG1_DIR_LSB 9
`define SCR_CFG1_OP_SEL 4
`define SCR_CFG1_BRAKE 3
`define SCR_CFG1_TMO_MSB 2
`define SCR_CFG1_TMO_LSB 1
`define SCR_CFG1_OVR_EN 0
`define SCR_CFG2_TOP_SPEED 8
`define SCR_CFG2_PIN_OFF 7
`define SCR_CFG2_PULSE_RES 6
`define SCR_CFG2_BAUD_HIGH 2
`define SCR_CFG2_BAUD_LOW 1

// ***************************************************************
// flash slots
// ***************************************************************
`define SCR_NUM_SLOTS 19
`define SCR_LAST_SLOT 5'd18
`define SCR_SLOT_CFG1 5'd12
`define SCR_SLOT_CFG2 5'd13
`define SCR_FLASH_DEPTH 32

// ***************************************************************
// timing
// ***************************************************************
`define SCR_CLK_PERIOD_NS 5
`define SCR_CLK_PER_MS 200000
`define SCR_PROG_TIME_NS 20000
`define SCR_PROG_CYC ((`SCR_PROG_TIME_NS + `SCR_CLK_PERIOD_NS - 1) / `SCR_CLK_PERIOD_NS)
`define SCR_TMO_SHORT_MS 50
`define SCR_TMO_MID_MS 500
`define SCR_TMO_LONG_MS 2800

`endif

// ==== core/scr_flash.v ====
// non-volatile store of saved register words, one slot per save-select bit
// assumes contents survive rst_n; read data is registered
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"

module scr_flash (
	input wire sys_clk,
	input wire rst_n,
	input wire wr_en,
	input wire [4:0] addr,
	input wire [14:0] wr_data,
	output reg [14:0] rd_data
);

	reg [14:0] mem [0:`SCR_FLASH_DEPTH-1];
	integer i;

	// erased at power-up only
	initial begin
		for (i = 0; i < `SCR_FLASH_DEPTH; i = i + 1) begin
			mem[i] = 15'h0000;
		end
	end

	always @(posedge sys_clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 15'h0000;
		end else begin
			rd_data <= mem[addr];
		end
	end

endmodule // scr_flash

`default_nettype wire

// ==== core/scr_core.v ====
// save-select and configuration registers behind the addressed serial link
// assumes rx bytes arrive synchronous to sys_clk, one per rx_valid pulse
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"

// Operation
// - writing the first save-select register only records marks
// - writing the second save-select records marks and starts the flash save
// - saved values reload from flash at every restart
// - saved registers get locked against on-board inputs
// - during a save PWM halts and all commands are refused
// - first select bits 13,12,11 and 9..6 mark settings, node id, limits
// - first select bits 5..0 mark ramps, currents and motor rates
// - second select bits 4..0 mark knob limits, compensations, sense trim
// - config one bits 12..9 set motor directions, both clear stops
// - operation_select 0 drives, 1 brakes or free-runs by brake_style
// - brake_style 0 coasts, 1 regenerates when back voltage is higher
// - timeout code clears speed after 50, 500 or 2800 ms without update
// - serial_override_enable gates every config one output, not the config two bits
// - serial writes set the config one bits, restart clears them unless saved in flash slot 12
// - config two is write-one-to-clear
// - write frame is address, command, two data bytes, 7-bit checksum
// - read reply is two data bytes and checksum including the command
module scr_core #(
	parameter [31:0] TMO_SHORT_CYC = `SCR_TMO_SHORT_MS * `SCR_CLK_PER_MS,
	parameter [31:0] TMO_MID_CYC = `SCR_TMO_MID_MS * `SCR_CLK_PER_MS,
	parameter [31:0] TMO_LONG_CYC = `SCR_TMO_LONG_MS * `SCR_CLK_PER_MS
) (
	input wire sys_clk,
	input wire rst_n,
	input wire [6:0] unit_addr,
	input wire rx_valid,
	input wire [7:0] rx_byte,
	output reg tx_valid,
	output reg [7:0] tx_byte,
	input wire speed_update,
	input wire [13:0] save_value,
	output wire [4:0] save_index,
	output reg restore_valid,
	output reg [4:0] restore_index,
	output reg [13:0] restore_data,
	output reg [18:0] lock_mask,
	output wire save_busy,
	output wire pwm_halt,
	output reg [3:0] motor_dir,
	output reg brake_active,
	output reg regen_enable,
	output reg speed_clear,
	output reg [4:0] cfg2_bits
);

	localparam [4:0] P_ADDR = 5'b00001;
	localparam [4:0] P_CMD = 5'b00010;
	localparam [4:0] P_D1 = 5'b00100;
	localparam [4:0] P_D2 = 5'b01000;
	localparam [4:0] P_CRC = 5'b10000;
	localparam [4:0] F_BOOT = 5'b00001;
	localparam [4:0] F_LOAD = 5'b00010;
	localparam [4:0] F_IDLE = 5'b00100;
	localparam [4:0] F_PROG = 5'b01000;
	localparam [4:0] F_WAIT = 5'b10000;
	localparam integer PROG_LAST_INT = `SCR_PROG_CYC - 1;
	localparam [12:0] PROG_LAST = PROG_LAST_INT[12:0];

	function [6:0] crc7;
		input [7:0] a;
		input [6:0] b;
		input [6:0] c;
		reg [8:0] s;
		begin
			s = {1'b0, a} + {2'b00, b} + {2'b00, c};
			crc7 = s[6:0] & `SCR_MASK7;
		end
	endfunction

	reg [13:0] save1, save2, cfg1, cfg2;
	reg [4:0] pstate;
	reg [4:0] fstate;
	reg [7:0] cmd;
	reg [6:0] d1, d2;
	reg [4:0] slot;
	reg [12:0] prog_cnt;
	reg [13:0] reply_word;
	reg [7:0] reply_cmd;
	reg [1:0] tx_cnt;
	reg [31:0] tmo_cnt;
	reg tmo_expired;
	reg [1:0] tmo_code_q;
	reg [31:0] tmo_limit;
	wire [14:0] fl_rdata;
	wire [18:0] marks;
	wire data_byte, is_write, is_read, wr_go, rd_go, fl_we, ovr;
	wire [13:0] prog_value;
	wire [3:0] next_motor_dir;

	// ***************************************************************
	// frame parser
	// ***************************************************************
	assign save_busy = (fstate != F_IDLE);
	assign pwm_halt = save_busy;
	assign data_byte = rx_valid && !rx_byte[7];
	assign is_write = (cmd == `SCR_CMD_WR_SAVE1) || (cmd == `SCR_CMD_WR_SAVE2) ||
		(cmd == `SCR_CMD_WR_CFG1) || (cmd == `SCR_CMD_WR_CFG2);
	assign is_read = (rx_byte == `SCR_CMD_RD_SAVE1) || (rx_byte == `SCR_CMD_RD_SAVE2) ||
		(rx_byte == `SCR_CMD_RD_CFG1) || (rx_byte == `SCR_CMD_RD_CFG2);
	// checksum of command and both data bytes
	assign wr_go = !save_busy && (pstate == P_CRC) && data_byte &&
		(rx_byte[6:0] == crc7(cmd, d1, d2));
	assign rd_go = !save_busy && (pstate == P_CMD) && data_byte && is_read;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pstate <= P_ADDR;
			cmd <= 8'h00;
			d1 <= 7'h00;
			d2 <= 7'h00;
		end else if (save_busy) begin
			pstate <= P_ADDR;
		end else if (rx_valid && rx_byte[7]) begin
			pstate <= (rx_byte[6:0] == unit_addr) ? P_CMD : P_ADDR;
		end else if (rx_valid) begin
			case (pstate)
				P_CMD: begin
					cmd <= rx_byte;
					pstate <= P_D1;
				end
				P_D1: begin
					d1 <= rx_byte[6:0];
					pstate <= is_write ? P_D2 : P_ADDR;
				end
				P_D2: begin
					d2 <= rx_byte[6:0];
					pstate <= P_CRC;
				end
				P_CRC: begin
					pstate <= P_ADDR;
				end
				default: begin
					pstate <= P_ADDR;
				end
			endcase
		end
	end

	// ***************************************************************
	// read reply
	// ***************************************************************
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_cnt <= 2'd0;
			tx_valid <= 1'b0;
			tx_byte <= 8'h00;
			reply_word <= 14'h0000;
			reply_cmd <= 8'h00;
		end else if (rd_go) begin
			reply_cmd <= rx_byte;
			case (rx_byte)
				`SCR_CMD_RD_SAVE1: reply_word <= save1;
				`SCR_CMD_RD_SAVE2: reply_word <= save2;
				`SCR_CMD_RD_CFG1: reply_word <= cfg1;
				default: reply_word <= cfg2;
			endcase
			tx_cnt <= 2'd3;
			tx_valid <= 1'b0;
		end else if (tx_cnt != 2'd0) begin
			tx_valid <= 1'b1;
			tx_cnt <= tx_cnt - 2'd1;
			case (tx_cnt)
				2'd3: tx_byte <= {1'b0, reply_word[13:7]};
				2'd2: tx_byte <= {1'b0, reply_word[6:0]};
				default: tx_byte <= {1'b0, crc7(reply_cmd, reply_word[13:7],
					reply_word[6:0])};
			endcase
		end else begin
			tx_valid <= 1'b0;
		end
	end

	// ***************************************************************
	// registers
	// ***************************************************************
	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			save1 <= `SCR_SAVE1_RESET;
			save2 <= `SCR_SAVE2_RESET;
			cfg1 <= `SCR_CFG1_RESET;
			cfg2 <= `SCR_CFG2_RESET;
		end else if (fstate == F_LOAD && fl_rdata[14]) begin
			if (slot == `SCR_SLOT_CFG1) begin
				cfg1 <= fl_rdata[13:0] & `SCR_CFG1_MASK;
			end
			if (slot == `SCR_SLOT_CFG2) begin
				cfg2 <= fl_rdata[13:0] & `SCR_CFG2_MASK;
			end
		end else if (wr_go) begin
			case (cmd)
				`SCR_CMD_WR_SAVE1: save1 <= {d1, d2} & `SCR_SAVE1_MASK;
				`SCR_CMD_WR_SAVE2: save2 <= {d1, d2} & `SCR_SAVE2_MASK;
				`SCR_CMD_WR_CFG1: cfg1 <= {d1, d2} & `SCR_CFG1_MASK;
				`SCR_CMD_WR_CFG2: cfg2 <= cfg2 & ~({d1, d2} & `SCR_CFG2_MASK);
				default: cfg2 <= cfg2;
			endcase
		end
	end

	// ***************************************************************
	// save and restore walk
	// ***************************************************************
	assign marks = {save2[4:0], save1};
	assign prog_value = (slot == `SCR_SLOT_CFG1) ? cfg1 :
		(slot == `SCR_SLOT_CFG2) ? cfg2 : save_value;
	assign fl_we = (fstate == F_PROG) && marks[slot];
	assign save_index = slot;

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fstate <= F_BOOT;
			slot <= 5'd0;
			prog_cnt <= 13'd0;
			lock_mask <= 19'h00000;
			restore_valid <= 1'b0;
			restore_index <= 5'd0;
			restore_data <= 14'h0000;
		end else begin
			restore_valid <= 1'b0;
			case (fstate)
				F_BOOT: begin
					fstate <= F_LOAD;
				end
				F_LOAD: begin
					if (fl_rdata[14]) begin
						restore_valid <= 1'b1;
						restore_index <= slot;
						restore_data <= fl_rdata[13:0];
						lock_mask[slot] <= 1'b1;
					end
					slot <= (slot == `SCR_LAST_SLOT) ? 5'd0 : slot + 5'd1;
					fstate <= (slot == `SCR_LAST_SLOT) ? F_IDLE : F_BOOT;
				end
				F_IDLE: begin
					if (wr_go && cmd == `SCR_CMD_WR_SAVE2) begin
						slot <= 5'd0;
						fstate <= F_PROG;
					end
				end
				F_PROG: begin
					prog_cnt <= 13'd0;
					if (marks[slot]) begin
						lock_mask[slot] <= 1'b1;
						fstate <= F_WAIT;
					end else if (slot == `SCR_LAST_SLOT) begin
						slot <= 5'd0;
						fstate <= F_IDLE;
					end else begin
						slot <= slot + 5'd1;
					end
				end
				F_WAIT: begin
					if (prog_cnt == PROG_LAST) begin
						// resume only after the last slot is programmed
						slot <= (slot == `SCR_LAST_SLOT) ? 5'd0 : slot + 5'd1;
						fstate <= (slot == `SCR_LAST_SLOT) ? F_IDLE : F_PROG;
					end else begin
						prog_cnt <= prog_cnt + 13'd1;
					end
				end
				default: begin
					fstate <= F_IDLE;
				end
			endcase
		end
	end

	scr_flash scr_flash_inst (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.wr_en(fl_we),
		.addr(slot),
		.wr_data({1'b1, prog_value}),
		.rd_data(fl_rdata)
	);

	// ***************************************************************
	// drive configuration outputs
	// ***************************************************************
	assign ovr = cfg1[`SCR_CFG1_OVR_EN];

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_dir
			assign next_motor_dir[g] = ovr && cfg1[`SCR_CFG1_DIR_LSB + g];
		end
	endgenerate

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			motor_dir <= 4'h0;
			brake_active <= 1'b0;
			regen_enable <= 1'b0;
			cfg2_bits <= 5'd0;
		end else begin
			motor_dir <= next_motor_dir;
			brake_active <= ovr && cfg1[`SCR_CFG1_OP_SEL];
			regen_enable <= ovr && cfg1[`SCR_CFG1_OP_SEL] && cfg1[`SCR_CFG1_BRAKE];
			cfg2_bits <= {cfg2[`SCR_CFG2_TOP_SPEED], cfg2[`SCR_CFG2_PIN_OFF],
				cfg2[`SCR_CFG2_PULSE_RES], cfg2[`SCR_CFG2_BAUD_HIGH],
				cfg2[`SCR_CFG2_BAUD_LOW]};
		end
	end

	// ***************************************************************
	// speed update watchdog
	// ***************************************************************
	always @* begin
		case (cfg1[`SCR_CFG1_TMO_MSB:`SCR_CFG1_TMO_LSB])
			2'b01: tmo_limit = TMO_SHORT_CYC - 32'd1;
			2'b10: tmo_limit = TMO_MID_CYC - 32'd1;
			default: tmo_limit = TMO_LONG_CYC - 32'd1;
		endcase
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tmo_cnt <= 32'd0;
			tmo_expired <= 1'b0;
			tmo_code_q <= 2'b00;
			speed_clear <= 1'b0;
		end else begin
			tmo_code_q <= cfg1[`SCR_CFG1_TMO_MSB:`SCR_CFG1_TMO_LSB];
			speed_clear <= 1'b0;
			if (speed_update || !ovr || tmo_code_q == 2'b00 ||
				tmo_code_q != cfg1[`SCR_CFG1_TMO_MSB:`SCR_CFG1_TMO_LSB]) begin
				tmo_cnt <= 32'd0;
				tmo_expired <= 1'b0;
			end else if (!tmo_expired) begin
				if (tmo_cnt >= tmo_limit) begin
					speed_clear <= 1'b1;
					tmo_expired <= 1'b1;
				end else begin
					tmo_cnt <= tmo_cnt + 32'd1;
				end
			end
		end
	end

endmodule // scr_core

`default_nettype wire

// ==== verif/scr_core_properties.sv ====
// port assertions for the save and configuration register bank
// assumes one clock domain, rst_n asynchronous and active low
`timescale 1ns/10ps
`default_nettype none
module scr_core_properties (
	input wire sys_clk,
	input wire rst_n,
	input wire rx_valid,
	input wire [7:0] rx_byte,
	input wire tx_valid,
	input wire [7:0] tx_byte,
	input wire restore_valid,
	input wire [18:0] lock_mask,
	input wire save_busy,
	input wire pwm_halt,
	input wire [4:0] save_index,
	input wire brake_active,
	input wire regen_enable,
	input wire speed_clear
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ***************************************************************
	// reply framing
	// ***************************************************************
	sequence s_reply;
		tx_valid [*3] ##1 !tx_valid;
	endsequence
	// checksum byte folds in the command taken two cycles before the reply
	sequence s_crc;
		##2 (tx_byte == (($past(tx_byte, 2) + $past(tx_byte, 1) + $past(rx_byte, 4)) & 8'h7f));
	endsequence
	a_reply_three_bytes: assert property ($rose(tx_valid) |-> s_reply)
		else $error("reply is not three bytes");
	a_reply_crc_sum: assert property ($rose(tx_valid) |-> s_crc)
		else $error("reply checksum wrong");
	// ***************************************************************
	// save and restore
	// ***************************************************************
	a_halt_tracks_busy: assert property (pwm_halt == save_busy)
		else $error("pwm halt differs from busy");
	a_quiet_while_saving: assert property (save_busy |-> !tx_valid)
		else $error("reply sent while busy");
	a_restore_in_boot: assert property (restore_valid |-> save_busy || $past(save_busy))
		else $error("restore outside boot walk");
	a_lock_only_grows: assert property ((lock_mask & $past(lock_mask)) == $past(lock_mask))
		else $error("lock bit dropped");
	a_walk_in_range: assert property (save_busy |-> save_index <= 5'd18)
		else $error("save index out of range");
	// ***************************************************************
	// drive outputs
	// ***************************************************************
	a_regen_needs_brake: assert property (regen_enable |-> brake_active)
		else $error("regen without brake mode");
	a_clear_one_cycle: assert property (speed_clear |=> !speed_clear)
		else $error("speed clear longer than one cycle");
endmodule // scr_core_properties
bind scr_core scr_core_properties scr_core_properties_inst (.sys_clk(sys_clk), .rst_n(rst_n),
	.rx_valid(rx_valid), .rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
	.restore_valid(restore_valid), .lock_mask(lock_mask), .save_busy(save_busy),
	.pwm_halt(pwm_halt), .save_index(save_index), .brake_active(brake_active),
	.regen_enable(regen_enable), .speed_clear(speed_clear));
`default_nettype wire

// ==== verif/scr_host.sv ====
// host model issuing addressed serial register frames
// assumes bytes are taken on the rising edge with rx_valid high
`timescale 1ns/10ps
`default_nettype none
module scr_host (
	input wire sys_clk,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire tx_valid,
	input wire [7:0] tx_byte
);
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	task automatic put(input logic [7:0] b);
		@(posedge sys_clk);
		rx_valid <= 1'b1;
		rx_byte <= b;
	endtask
	// released line shows the inverse of the last byte
	task automatic idle;
		@(posedge sys_clk);
		rx_valid <= 1'b0;
		rx_byte <= ~rx_byte;
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [13:0] w);
		put({1'b1, a});
		put(c);
		put({1'b0, w[13:7]});
		put({1'b0, w[6:0]});
		put((c + w[13:7] + w[6:0]) & 8'h7f);
		idle();
	endtask
	task automatic rd(input logic [6:0] a, input logic [7:0] c, output logic [13:0] w,
		output logic ok);
		logic [7:0] r [0:2];
		int n;
		n = 0;
		put({1'b1, a});
		put(c);
		idle();
		for (int i = 0; i < 8; i++) begin
			@(posedge sys_clk);
			if (tx_valid === 1'b1 && n < 3) begin
				r[n] = tx_byte;
				n++;
			end
		end
		w = {r[0][6:0], r[1][6:0]};
		ok = (n == 3) && (r[2] === ((r[0] + r[1] + c) & 8'h7f));
	endtask
endmodule // scr_host
`default_nettype wire

// ==== verif/scr_core_bench.sv ====
// self-checking bench of the save and configuration register bank
// assumes the host model drives the serial link; timeouts shortened
`timescale 1ns/10ps
`default_nettype none
`include "scr_regs.vh"
module scr_core_bench;
	localparam logic [6:0] ADDR = 7'h05;
	logic sys_clk, rst_n, rx_valid, tx_valid, speed_update, restore_valid, save_busy;
	logic pwm_halt, brake_active, regen_enable, speed_clear;
	logic [7:0] rx_byte, tx_byte;
	logic [13:0] save_value, restore_data;
	logic [4:0] save_index, restore_index, cfg2_bits;
	logic [18:0] lock_mask;
	logic [3:0] motor_dir;
	int bad_count = 0;
	int num_checks = 0;
	scr_core #(.TMO_SHORT_CYC(50), .TMO_MID_CYC(100), .TMO_LONG_CYC(200)) scr_core_inst (
		.sys_clk(sys_clk), .rst_n(rst_n), .unit_addr(ADDR), .rx_valid(rx_valid),
		.rx_byte(rx_byte), .tx_valid(tx_valid), .tx_byte(tx_byte),
		.speed_update(speed_update), .save_value(save_value), .save_index(save_index),
		.restore_valid(restore_valid), .restore_index(restore_index),
		.restore_data(restore_data), .lock_mask(lock_mask), .save_busy(save_busy),
		.pwm_halt(pwm_halt), .motor_dir(motor_dir), .brake_active(brake_active),
		.regen_enable(regen_enable), .speed_clear(speed_clear), .cfg2_bits(cfg2_bits));
	scr_host scr_host_inst (.sys_clk(sys_clk), .rx_valid(rx_valid), .rx_byte(rx_byte),
		.tx_valid(tx_valid), .tx_byte(tx_byte));
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [18:0] seen, input logic [18:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ***************************************************************
	// helpers
	// ***************************************************************
	task automatic do_reset(output int nr);
		nr = 0;
		rst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 100; i++) begin
			@(posedge sys_clk);
			if (restore_valid === 1'b1) begin
				nr++;
				chk("restore data", restore_data, 14'h2a5c);
				chk("restore index", restore_index, (nr == 1) ? 5'd0 : 5'd14);
			end
		end
	endtask
	task automatic rdchk(input logic [7:0] c, input logic [13:0] e, input logic eok,
		input string nm);
		logic [13:0] w;
		logic ok;
		scr_host_inst.rd(ADDR, c, w, ok);
		chk(nm, ok, eok);
		if (eok)
			chk(nm, w, e);
	endtask
	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic t_regs;
		rdchk(`SCR_CMD_RD_SAVE1, `SCR_SAVE1_RESET, 1, "save1 reset");
		rdchk(`SCR_CMD_RD_SAVE2, `SCR_SAVE2_RESET, 1, "save2 reset");
		rdchk(`SCR_CMD_RD_CFG1, `SCR_CFG1_RESET, 1, "cfg1 reset");
		rdchk(`SCR_CMD_RD_CFG2, `SCR_CFG2_RESET, 1, "cfg2 reset");
		scr_host_inst.wr(ADDR, `SCR_CMD_WR_SAVE1, 14'h3fff);
		repeat (2) @(posedge sys_clk);
		chk("save1 no start", save_busy, 0);
		rdchk(`SCR_CMD_RD_SAVE1, `SCR_SAVE1_MASK, 1, "save1 marks");
		scr_host_inst.wr(ADDR, `SCR_CMD_WR_SAVE1, 14'h0001);
		scr_host_inst.wr(ADDR, `SCR_CMD_WR_CFG2, 14'h3fff);
		rdchk(`SCR_CMD_RD_CFG2, 14'h0000, 1, "cfg2 clear");
		chk("cfg2 bits", cfg2_bits, 5'h00);
		rdchk(8'h36, 14'h0000, 0, "unmapped");
		scr_host_inst.wr(ADDR + 7'h01, `SCR_CMD_WR_CFG1, 14'h0001);
		rdchk(`SCR_CMD_RD_CFG1, 14'h0000, 1, "other unit");
	endtask
	task automatic t_cfg;
		logic [13:0] tbl [5] = '{14'h1e19, 14'h1e18, 14'h0219, 14'h1401, 14'h0211};
		logic [13:0] w;
		foreach (tbl[i]) begin
			w = tbl[i];
			scr_host_inst.wr(ADDR, `SCR_CMD_WR_CFG1, w);
			repeat (3) @(posedge sys_clk);
			chk("motor dir", motor_dir, w[0] ? w[12:9] : 4'h0);
			chk("brake", brake_active, w[0] & w[4]);
			chk("regen", regen_enable, w[0] & w[4] & w[3]);
			rdchk(`SCR_CMD_RD_CFG1, w & `SCR_CFG1_MASK, 1, "cfg1 back");
		end
	endtask
	task automatic t_tmo;
		int tmo [4] = '{0, 50, 100, 200};
		int n;
		for (int c = 0; c < 4; c++) begin
			scr_host_inst.wr(ADDR, `SCR_CMD_WR_CFG1, 14'(c * 2 + 1));
			@(posedge sys_clk) speed_update <= 1'b1;
			@(posedge sys_clk) speed_update <= 1'b0;
			n = 0;
			while (speed_clear !== 1'b1 && n < 300) begin
				@(posedge sys_clk);
				n++;
			end
			if (c == 0)
				chk("no clear", n, 300);
			else
				chk("clear window", n >= tmo[c] - 2 && n <= tmo[c] + 4, 1);
		end
	endtask
	task automatic t_save;
		int nr;
		// one save only, flash wear is limited
		scr_host_inst.wr(ADDR, `SCR_CMD_WR_SAVE2, 14'h0001);
		repeat (2) @(posedge sys_clk);
		chk("save busy", save_busy, 1);
		chk("pwm halt", pwm_halt, 1);
		chk("save index", save_index, 5'd0);
		rdchk(`SCR_CMD_RD_SAVE1, 14'h0000, 0, "read in save");
		for (int i = 0; i < 20000 && save_busy !== 1'b0; i++)
			@(posedge sys_clk);
		chk("lock after save", lock_mask, 19'h04001);
		rdchk(`SCR_CMD_RD_SAVE2, 14'h0001, 1, "save2 marks");
		do_reset(nr);
		chk("restore count", nr, 2);
		chk("lock after boot", lock_mask, 19'h04001);
		rdchk(`SCR_CMD_RD_CFG1, 14'h0000, 1, "cfg1 restart");
	endtask
	initial begin
		int nr;
		rst_n = 1'b0;
		speed_update = 1'b0;
		save_value = 14'h2a5c;
		do_reset(nr);
		t_regs();
		t_cfg();
		t_tmo();
		t_save();
		final_report();
	end
	initial begin
		#400000;
		bad_count++;
		final_report();
	end
endmodule // scr_core_bench
`default_nettype wire
